// File: rtl/dac_cal_map.vh
// Register map, field positions, reset values and timing counts.
`ifndef DAC_CAL_MAP_VH
`define DAC_CAL_MAP_VH
`define ADDR_IRQ          5'h01
`define ADDR_CUR_HIGH     5'h02
`define ADDR_CUR_LOW      5'h03
`define ADDR_SETUP_HOLD   5'h04
`define ADDR_SAMPLE_STAT  5'h05
`define ADDR_INPUT_CTRL   5'h06
`define ADDR_FIFO_STAT    5'h07
`define ADDR_FIFO_CTRL    5'h08
`define RST_FULL_SCALE    10'h200
`define RST_ZERO4         4'h0
`define FILTER_MAX        4'hc
`define FRAC_BITS         12
`define FRAC_ZERO         12'h000
`define FIFO_POS_LO       3'h0
`define FIFO_POS_LO2      3'h1
`define FIFO_POS_HI2      3'h6
`define FIFO_POS_HI       3'h7
`define FIFO_POS_MID      3'h4
`define SPI_INSTR_LAST    4'h7
`define SPI_DATA_LAST     4'hf
`define SPI_RD_BIT        7
`endif

// File: rtl/dac_timing_calibration_regs.v
// Serial-port register bank with input-timing and FIFO pointer controllers.
`timescale 1ns/1ns
`include "dac_cal_map.vh"
module dac_timing_calibration_regs (
	input  wire       core_clk,
	input  wire       srst,
	input  wire       spi_cs_n,
	input  wire       spi_sclk,
	input  wire       spi_sdi,
	output reg        spi_sdo,
	output reg        spi_sdo_en_n,
	output reg        irq_n,
	output reg  [9:0] full_scale_code,
	output reg        output_sleep,
	output reg        output_current_off,
	output reg  [3:0] meas_setup_delay,
	output reg  [3:0] meas_hold_delay,
	output reg  [3:0] sample_delay,
	output reg  [1:0] read_pointer_offset,
	output reg        input_meas_run,
	output reg        fifo_meas_run,
	input  wire       input_meas_done,
	input  wire [3:0] input_meas_delay,
	input  wire [3:0] input_meas_setup,
	input  wire [3:0] input_meas_hold,
	input  wire       input_phase_ok,
	input  wire       input_over_limit,
	input  wire       input_under_limit,
	input  wire       fifo_meas_done,
	input  wire [2:0] fifo_meas_pos,
	input  wire       fifo_sync_error
);

	reg        sclk_q;
	reg  [3:0] bit_cnt_q;
	reg        done_q;
	reg  [7:0] instr_q;
	reg  [7:0] shift_q;
	reg  [7:0] rd_shift_q;
	reg        reading_q;
	reg  [7:0] rdata;

	reg  [9:0] fsc_q;
	reg        sleep_q;
	reg  [3:0] wr_setup_q;
	reg  [3:0] wr_hold_q;
	reg  [3:0] wr_sd_q;
	reg  [3:0] auto_setup_q;
	reg  [3:0] auto_hold_q;
	reg  [3:0] auto_sd_q;
	reg        in_surv_q;
	reg        in_auto_q;
	reg  [3:0] in_flt_q;
	reg  [1:0] in_thr_q;
	reg        in_changed_q;
	reg  [3:0] in_prev_q;
	reg        phase_ok_q;
	reg        over_q;
	reg        under_q;
	reg [15:0] in_acc_q;
	reg        in_run_q;

	reg  [1:0] wr_ofs_q;
	reg  [1:0] auto_ofs_q;
	reg        f_surv_q;
	reg        f_auto_q;
	reg  [3:0] f_flt_q;
	reg        f_thr_q;
	reg  [3:0] f_stat_q;
	reg        f_valid_q;
	reg        f_changed_q;
	reg [14:0] f_acc_q;
	reg        f_run_q;

	reg        ie_in_q;
	reg        ie_f_q;
	reg        pend_in_q;
	reg        pend_f_q;

	wire sclk_rise = spi_sclk & ~sclk_q;
	wire sclk_fall = ~spi_sclk & sclk_q;
	wire instr_done = sclk_rise & ~done_q & (bit_cnt_q == `SPI_INSTR_LAST);
	wire data_done = sclk_rise & ~done_q & (bit_cnt_q == `SPI_DATA_LAST);
	wire [7:0] wdata = {shift_q[6:0], spi_sdi};
	wire wr = data_done & ~instr_q[`SPI_RD_BIT];
	wire [4:0] waddr = instr_q[4:0];
	wire wr_irq = wr && (waddr == `ADDR_IRQ);
	wire wr_in_ctrl = wr && (waddr == `ADDR_INPUT_CTRL);
	wire wr_f_ctrl = wr && (waddr == `ADDR_FIFO_CTRL);

	// Filtered input delay: four integer bits over twelve fraction bits.
	wire [3:0] in_len = (in_flt_q > `FILTER_MAX) ? `FILTER_MAX :
		in_flt_q;
	wire [15:0] in_target = {input_meas_delay, `FRAC_ZERO};
	wire signed [16:0] in_delta = $signed({1'b0, in_target}) -
		$signed({1'b0, in_acc_q});
	wire signed [16:0] in_step = in_delta >>> in_len;
	wire [15:0] in_acc_d = in_acc_q + in_step[15:0];
	wire [3:0] in_filt = in_acc_d[15:`FRAC_BITS];
	wire [3:0] in_cur = in_auto_q ? auto_sd_q : wr_sd_q;
	wire [3:0] in_dist = (in_filt > in_cur) ? in_filt - in_cur :
		in_cur - in_filt;
	wire in_drift = in_dist > {2'b00, in_thr_q};

	wire [14:0] f_target = {fifo_meas_pos, `FRAC_ZERO};
	wire signed [15:0] f_delta = $signed({1'b0, f_target}) -
		$signed({1'b0, f_acc_q});
	wire signed [15:0] f_step = f_delta >>> f_flt_q;
	wire [14:0] f_acc_d = f_acc_q + f_step[14:0];
	wire [2:0] f_filt = f_acc_d[14:`FRAC_BITS];
	wire f_edge = (f_filt == `FIFO_POS_LO) || (f_filt == `FIFO_POS_HI);
	wire f_near = (f_filt == `FIFO_POS_LO2) || (f_filt == `FIFO_POS_HI2);
	wire f_drift = f_edge | (f_thr_q & f_near);
	wire [2:0] f_shift = `FIFO_POS_MID - f_filt;
	wire [1:0] f_ofs_cur = f_auto_q ? auto_ofs_q : wr_ofs_q;
	wire [1:0] f_ofs_new = f_ofs_cur + f_shift[1:0];

	wire in_ev = input_meas_done & in_run_q & in_surv_q & in_drift;
	wire f_ev = fifo_meas_done & f_run_q & f_surv_q & f_drift;

	always @* begin
		rdata = 8'h00;
		if (waddr == `ADDR_IRQ) begin
			rdata = {pend_in_q, pend_f_q, 2'b00, ie_in_q, ie_f_q, 2'b00};
		end else if (waddr == `ADDR_CUR_HIGH) begin
			rdata = {sleep_q, 5'h00, fsc_q[9:8]};
		end else if (waddr == `ADDR_CUR_LOW) begin
			rdata = fsc_q[7:0];
		end else if (waddr == `ADDR_SETUP_HOLD) begin
			rdata = in_auto_q ? {auto_setup_q, auto_hold_q} :
				{wr_setup_q, wr_hold_q};
		end else if (waddr == `ADDR_SAMPLE_STAT) begin
			rdata = {in_cur, in_changed_q, over_q, under_q,
				phase_ok_q};
		end else if (waddr == `ADDR_INPUT_CTRL) begin
			rdata = {in_surv_q, in_auto_q, in_flt_q, in_thr_q};
		end else if (waddr == `ADDR_FIFO_STAT) begin
			rdata = {f_stat_q, f_valid_q, f_changed_q, f_ofs_cur};
		end else if (waddr == `ADDR_FIFO_CTRL) begin
			rdata = {f_surv_q, f_auto_q, f_flt_q, 1'b0, f_thr_q};
		end
	end

	// Serial port: sampled on rising clock, shifted out on falling clock.
	always @(posedge core_clk) begin
		if (srst) begin
			sclk_q <= 1'b0;
			bit_cnt_q <= 4'h0;
			done_q <= 1'b0;
			instr_q <= 8'h00;
			shift_q <= 8'h00;
			rd_shift_q <= 8'h00;
			reading_q <= 1'b0;
			spi_sdo <= 1'b0;
			spi_sdo_en_n <= 1'b1;
		end else begin
			sclk_q <= spi_sclk;
			if (spi_cs_n) begin
				bit_cnt_q <= 4'h0;
				done_q <= 1'b0;
				reading_q <= 1'b0;
				spi_sdo_en_n <= 1'b1;
			end else begin
				if (sclk_rise && !done_q) begin
					shift_q <= wdata;
					bit_cnt_q <= bit_cnt_q + 4'h1;
					if (data_done)
						done_q <= 1'b1;
				end
				if (instr_done) begin
					instr_q <= wdata;
					reading_q <= wdata[`SPI_RD_BIT];
				end
				if (reading_q && instr_done == 1'b0 &&
					bit_cnt_q == (`SPI_INSTR_LAST + 4'h1) &&
					rd_shift_q == 8'h00 && spi_sdo_en_n) begin
					rd_shift_q <= rdata;
				end
				if (sclk_fall && reading_q) begin
					if (spi_sdo_en_n) begin
						spi_sdo <= rdata[7];
						rd_shift_q <= {rdata[6:0], 1'b0};
						spi_sdo_en_n <= 1'b0;
					end else begin
						spi_sdo <= rd_shift_q[7];
						rd_shift_q <= {rd_shift_q[6:0], 1'b0};
					end
				end
			end
		end
	end

	// Plain written registers and interrupt enables.
	always @(posedge core_clk) begin
		if (srst) begin
			fsc_q <= `RST_FULL_SCALE;
			sleep_q <= 1'b0;
			wr_setup_q <= `RST_ZERO4;
			wr_hold_q <= `RST_ZERO4;
			wr_sd_q <= `RST_ZERO4;
			in_surv_q <= 1'b0;
			in_auto_q <= 1'b0;
			in_flt_q <= `RST_ZERO4;
			in_thr_q <= 2'b00;
			wr_ofs_q <= 2'b00;
			f_surv_q <= 1'b0;
			f_auto_q <= 1'b0;
			f_flt_q <= `RST_ZERO4;
			f_thr_q <= 1'b0;
			ie_in_q <= 1'b0;
			ie_f_q <= 1'b0;
		end else if (wr) begin
			if (waddr == `ADDR_IRQ) begin
				ie_in_q <= wdata[3];
				ie_f_q <= wdata[2];
			end else if (waddr == `ADDR_CUR_HIGH) begin
				sleep_q <= wdata[7];
				fsc_q[9:8] <= wdata[1:0];
			end else if (waddr == `ADDR_CUR_LOW) begin
				fsc_q[7:0] <= wdata;
			end else if (waddr == `ADDR_SETUP_HOLD) begin
				wr_setup_q <= wdata[7:4];
				wr_hold_q <= wdata[3:0];
			end else if (waddr == `ADDR_SAMPLE_STAT) begin
				wr_sd_q <= wdata[7:4];
			end else if (waddr == `ADDR_INPUT_CTRL) begin
				in_surv_q <= wdata[7];
				in_auto_q <= wdata[6];
				in_flt_q <= wdata[5:2];
				in_thr_q <= wdata[1:0];
			end else if (waddr == `ADDR_FIFO_STAT) begin
				wr_ofs_q <= wdata[1:0];
			end else if (waddr == `ADDR_FIFO_CTRL) begin
				f_surv_q <= wdata[7];
				f_auto_q <= wdata[6];
				f_flt_q <= wdata[5:2];
				f_thr_q <= wdata[0];
			end
		end
	end

	// Input-timing controller.
	always @(posedge core_clk) begin
		if (srst) begin
			in_run_q <= 1'b0;
			in_acc_q <= 16'h0000;
			auto_sd_q <= `RST_ZERO4;
			auto_setup_q <= `RST_ZERO4;
			auto_hold_q <= `RST_ZERO4;
			in_prev_q <= `RST_ZERO4;
			in_changed_q <= 1'b0;
			phase_ok_q <= 1'b0;
		end else begin
			if (wr_in_ctrl)
				in_run_q <= 1'b1;
			else if (input_meas_done && !in_surv_q && !in_auto_q)
				in_run_q <= 1'b0;
			if (input_meas_done && in_run_q) begin
				in_acc_q <= in_acc_d;
				in_prev_q <= input_meas_delay;
				in_changed_q <= (input_meas_delay != in_prev_q);
				phase_ok_q <= input_phase_ok;
				auto_setup_q <= input_meas_setup;
				auto_hold_q <= input_meas_hold;
				if (in_auto_q && in_drift)
					auto_sd_q <= in_filt;
			end
		end
	end

	// FIFO pointer controller.
	always @(posedge core_clk) begin
		if (srst) begin
			f_run_q <= 1'b0;
			f_acc_q <= 15'h0000;
			f_stat_q <= 4'h0;
			f_valid_q <= 1'b0;
			f_changed_q <= 1'b0;
			auto_ofs_q <= 2'b00;
		end else begin
			if (wr_f_ctrl)
				f_run_q <= 1'b1;
			else if (fifo_meas_done && !f_surv_q && !f_auto_q)
				f_run_q <= 1'b0;
			if (fifo_meas_done && f_run_q) begin
				f_acc_q <= f_acc_d;
				f_stat_q <= {fifo_sync_error, fifo_meas_pos};
				f_valid_q <= 1'b1;
				f_changed_q <= f_surv_q && f_valid_q &&
					({fifo_sync_error, fifo_meas_pos} != f_stat_q);
				if (f_auto_q && f_drift)
					auto_ofs_q <= f_ofs_new;
			end
		end
	end

	// Pending interrupts: a zero enable clears and blocks its source.
	always @(posedge core_clk) begin
		if (srst) begin
			pend_in_q <= 1'b0;
			pend_f_q <= 1'b0;
		end else begin
			if (wr_irq && !wdata[3])
				pend_in_q <= 1'b0;
			else if (ie_in_q && in_ev)
				pend_in_q <= 1'b1;
			if (wr_irq && !wdata[2])
				pend_f_q <= 1'b0;
			else if (ie_f_q && f_ev)
				pend_f_q <= 1'b1;
		end
	end

	// Registered outputs.
	always @(posedge core_clk) begin
		if (srst) begin
			irq_n <= 1'b1;
			full_scale_code <= `RST_FULL_SCALE;
			output_sleep <= 1'b0;
			output_current_off <= 1'b0;
			meas_setup_delay <= `RST_ZERO4;
			meas_hold_delay <= `RST_ZERO4;
			sample_delay <= `RST_ZERO4;
			read_pointer_offset <= 2'b00;
			input_meas_run <= 1'b0;
			fifo_meas_run <= 1'b0;
			over_q <= 1'b0;
			under_q <= 1'b0;
		end else begin
			irq_n <= ~((pend_in_q & ie_in_q) | (pend_f_q & ie_f_q));
			full_scale_code <= fsc_q;
			output_sleep <= sleep_q;
			output_current_off <= sleep_q;
			meas_setup_delay <= wr_setup_q;
			meas_hold_delay <= wr_hold_q;
			sample_delay <= in_cur;
			read_pointer_offset <= f_ofs_cur;
			input_meas_run <= in_run_q;
			fifo_meas_run <= f_run_q;
			over_q <= input_over_limit;
			under_q <= input_under_limit;
		end
	end

endmodule

// File: test/dac_cal_asserts.sv
// Concurrent checks on the calibration register bank ports.
`timescale 1ns/1ns
module dac_cal_asserts (
	input wire       core_clk,
	input wire       srst,
	input wire       spi_cs_n,
	input wire       spi_sdo_en_n,
	input wire       irq_n,
	input wire [9:0] full_scale_code,
	input wire       output_sleep,
	input wire       output_current_off,
	input wire [3:0] sample_delay,
	input wire [1:0] read_pointer_offset,
	input wire       input_meas_run,
	input wire       fifo_meas_run,
	input wire       input_meas_done,
	input wire       fifo_meas_done
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	sequence cs_idle3;
		spi_cs_n [*3];
	endsequence
	sequence fifo_quiet;
		(!fifo_meas_run && spi_cs_n) [*3];
	endsequence
	a_reset_quiet: assert property (disable iff (1'b0)
		srst |=> irq_n && spi_sdo_en_n && full_scale_code == 10'h200)
		else $error("reset values wrong");
	a_sleep_mirror: assert property (
		output_sleep == output_current_off)
		else $error("current off differs from sleep");
	a_delay_steady: assert property (
		cs_idle3 ##0 (!$past(input_meas_done) && !$past(srst)
		&& !$past(input_meas_done, 2)) |-> $stable(sample_delay))
		else $error("sample delay moved without cause");
	a_offset_steady: assert property (
		fifo_quiet |=> $stable(read_pointer_offset))
		else $error("pointer offset moved without cause");
	a_irq_cause: assert property (
		$fell(irq_n) |-> $past(input_meas_done, 2)
		|| $past(fifo_meas_done, 2))
		else $error("irq without measurement");
	a_fsc_by_spi: assert property (
		$changed(full_scale_code) && !$past(srst)
		|-> !$past(spi_cs_n) || !$past(spi_cs_n, 2))
		else $error("code changed outside a frame");
	a_input_run_src: assert property (
		$rose(input_meas_run) |-> !$past(spi_cs_n, 3))
		else $error("input run started without write");
	a_fifo_run_src: assert property (
		$rose(fifo_meas_run) |-> !$past(spi_cs_n, 3))
		else $error("fifo run started without write");
endmodule

// File: test/meas_src.sv
// Measurement source answering a running controller.
`timescale 1ns/1ns
module meas_src #(
	parameter W   = 4,
	parameter GAP = 300
) (
	input  wire         core_clk,
	input  wire         run,
	input  wire [W-1:0] val,
	output reg          done,
	output reg  [W-1:0] res
);
	integer cnt = 0;
	initial done = 1'b0;
	initial res = {W{1'b0}};
	// Between results the lines toggle so stale data never looks valid.
	always @(posedge core_clk) begin
		cnt <= run ? cnt + 1 : 0;
		done <= run && cnt % GAP == GAP - 1;
		res <= (run && cnt % GAP == GAP - 1) ? val : ~res;
	end
endmodule

// File: test/tb_dac_timing_calibration_regs.sv
// Self-checking bench for the calibration register bank.
`timescale 1ns/1ns
module tb_dac_timing_calibration_regs;
	reg        core_clk, srst, spi_cs_n, spi_sclk, spi_sdi, ovr, und;
	reg [12:0] iv;
	reg [3:0]  fv;
	wire       spi_sdo, spi_sdo_en_n, irq_n, output_sleep;
	wire       output_current_off, input_meas_run, fifo_meas_run;
	wire [9:0] full_scale_code;
	wire [3:0] meas_setup_delay, meas_hold_delay, sample_delay;
	wire [3:0] i_dl, i_su, i_ho, f_err_pos;
	wire [1:0] read_pointer_offset;
	wire       i_done, i_ph, f_done;
	integer    n_fail = 0, tests_run = 0, r, t, p;
	reg [27:0] rows [0:16] = '{28'h0020002, 28'h0030000, 28'h0040000,
		28'h0050000, 28'h0060000, 28'h0070000, 28'h0080000,
		28'h0010000, 28'h1028383, 28'h103ffff, 28'h104a5a5,
		28'h11f5500, 28'h101ff0c, 28'h1010000, 28'h1057f70,
		28'h1077f03, 28'h1070000};
	dac_timing_calibration_regs DUT (.core_clk, .srst, .spi_cs_n,
		.spi_sclk, .spi_sdi, .spi_sdo, .spi_sdo_en_n, .irq_n,
		.full_scale_code, .output_sleep, .output_current_off,
		.meas_setup_delay, .meas_hold_delay, .sample_delay,
		.read_pointer_offset, .input_meas_run, .fifo_meas_run,
		.input_meas_done(i_done), .input_meas_delay(i_dl),
		.input_meas_setup(i_su), .input_meas_hold(i_ho),
		.input_phase_ok(i_ph), .input_over_limit(ovr),
		.input_under_limit(und), .fifo_meas_done(f_done),
		.fifo_meas_pos(f_err_pos[2:0]), .fifo_sync_error(f_err_pos[3]));
	meas_src #(.W(13)) u_isrc (.core_clk, .run(input_meas_run),
		.val(iv), .done(i_done), .res({i_dl, i_su, i_ho, i_ph}));
	meas_src #(.W(4)) u_fsrc (.core_clk, .run(fifo_meas_run),
		.val(fv), .done(f_done), .res(f_err_pos));
	initial begin
		core_clk = 0;
		forever #50 core_clk = ~core_clk;
	end
	task chk(input string nm, input [31:0] s, input [31:0] e);
		begin
			tests_run = tests_run + 1;
			if (s !== e) begin
				n_fail = n_fail + 1;
				$display("[FAIL] %0s expected %h seen %h", nm, e, s);
			end
		end
	endtask
	// Each serial level lasts three clocks to clear input sampling lag.
	task spi(input [7:0] ins, input [7:0] wd, output [7:0] rd);
		integer i;
		begin
			rd = 8'h00;
			@(negedge core_clk) spi_cs_n = 0;
			for (i = 15; i >= 0; i = i - 1) begin
				spi_sdi = i > 7 ? ins[i - 8] : wd[i];
				repeat (3) @(negedge core_clk);
				if (i < 8) rd[i] = spi_sdo_en_n ? 1'bx : spi_sdo;
				spi_sclk = 1;
				repeat (3) @(negedge core_clk);
				spi_sclk = 0;
			end
			repeat (6) @(negedge core_clk);
			spi_cs_n = 1;
			spi_sdi = ~spi_sdi;
			@(negedge core_clk);
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		reg [7:0] x;
		spi(a, d, x);
	endtask
	task rdc(input [7:0] a, input [7:0] e);
		reg [7:0] x;
		begin
			spi(8'h80 | a, 8'h00, x);
			chk("register", x, e);
		end
	endtask
	// Waits for n result pulses, then lets the outputs settle.
	task wdone(input f, input integer n);
		integer k;
		begin
			for (k = 0; k < 2000 && n > 0; k = k + 1) begin
				@(negedge core_clk);
				if (f ? f_done : i_done) n = n - 1;
			end
			if (n > 0) chk("done", 0, 1);
			repeat (3) @(negedge core_clk);
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d mismatches %0d", tests_run, n_fail);
			if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
			else $display("RESULT: FAIL");
			$finish;
		end
	endtask
	initial begin
		srst = 1; spi_cs_n = 1; spi_sclk = 0; spi_sdi = 0;
		ovr = 0; und = 0; iv = {4'h5, 4'h3, 4'h6, 1'b1}; fv = 4'h4;
		repeat (20) @(negedge core_clk);
		srst = 0;
		chk("irq_n", irq_n, 1);
		for (r = 0; r < 17; r = r + 1) begin
			if (rows[r][24]) wr(rows[r][23:16], rows[r][15:8]);
			rdc(rows[r][23:16],
				rows[r][7:0]);
		end
		chk("ports", {full_scale_code, output_sleep, output_current_off,
			meas_setup_delay, meas_hold_delay, sample_delay},
			{10'h3ff, 2'b11, 12'ha57});
		wr(2, 0); wr(5, 0);
		chk("sleep", {output_sleep, output_current_off}, 0);
		ovr = 1; rdc(5, 8'h04); ovr = 0; und = 1;
		rdc(5, 8'h02); und = 0;
		$display("test registers done");
		wr(1, 8'h08); wr(6, 8'h80); wdone(0, 2);
		chk("irq_n", irq_n, 0);
		chk("sdelay", sample_delay, 0);
		rdc(1, 8'h88);
		wr(1, 0);
		chk("irq_n", irq_n, 1);
		wdone(0, 1); iv[12:9] = 4'h9; wr(6, 0); wdone(0, 1);
		chk("run", input_meas_run, 0);
		rdc(5, 8'h09);
		wr(1, 0); wr(6, 8'hc0); wdone(0, 2);
		chk("sdelay", sample_delay, 9);
		rdc(4, 8'h36);
		wdone(0, 1); iv[12:9] = 4'h1; wr(6, 8'hc4); wdone(0, 1);
		chk("sdelay", sample_delay, 5);
		wr(6, 0);
		chk("sdelay", sample_delay, 0);
		iv[12:9] = 4'h8;
		wr(6, 8'hc3);
		wdone(0, 1);
		chk("sdelay", sample_delay, 5);
		iv[12:9] = 4'h9;
		wdone(0, 1);
		chk("sdelay", sample_delay, 9);
		wr(6, 0);
		$display("test input timing done");
		for (t = 0; t < 2; t = t + 1) begin
			wr(8, 8'h80 | t);
			for (p = 0; p < 8; p = p + 1) begin
				fv = p; wr(1, 0); wr(1, 8'h04); wdone(1, 2);
				chk("irq_n", irq_n, !(p == 0 || p == 7 ||
					t && (p == 1 || p == 6)));
			end
		end
		fv = 4'h4; wdone(1, 2);
		rdc(7, 8'h48);
		fv = 4'hf; wdone(1, 1);
		rdc(7, 8'hfc);
		fv = 4'h7; wdone(1, 1); wr(1, 0); wr(8, 8'hc0); wdone(1, 1);
		chk("offset", read_pointer_offset, 1);
		$display("test fifo done");
		srst = 1; repeat (2) @(negedge core_clk); srst = 0;
		chk("reset", {irq_n, full_scale_code, read_pointer_offset,
			input_meas_run, fifo_meas_run}, {1'b1, 10'h200, 4'h0});
		rdc(8, 0);
		$display("test reset done");
		print_verdict;
	end
	initial begin
		#6000000;
		n_fail = n_fail + 1;
		print_verdict;
	end
endmodule
bind dac_timing_calibration_regs dac_cal_asserts u_chk (.core_clk,
	.srst, .spi_cs_n, .spi_sdo_en_n, .irq_n, .full_scale_code,
	.output_sleep, .output_current_off, .sample_delay,
	.read_pointer_offset, .input_meas_run, .fifo_meas_run,
	.input_meas_done, .fifo_meas_done);
